// file: framer_dev.sv
`timescale 1ns/100ps
`default_nettype none
module framer_dev
   import framer_pkg::*;
(
   input  wire logic     sys_rst,
   framer_bus_if.dev     bus,
   input  wire logic     rx_sig_we,
   input  wire sig_idx_t rx_sig_idx,
   input  wire byte_t    rx_sig_data,
   output logic          tx_sig_valid,
   output sig_idx_t      tx_sig_idx,
   output byte_t         tx_sig_data,
   output logic          line_mode_t1,
   output logic          tx_soft_reset,
   output logic          rx_soft_reset
);
   localparam int SYNC_W = 3 + ADDR_W + DATA_W;
   localparam int RCNT_W = $clog2(RESET_MIN_CYC + 1);
   localparam int SCNT_W = $clog2(SETTLE_CYC + 1);
   localparam logic [RCNT_W-1:0] RCNT_MAX = RCNT_W'(RESET_MIN_CYC);
   localparam logic [SCNT_W-1:0] SCNT_END = SCNT_W'(SETTLE_CYC - 1);

   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic              pin_rst_n;
   logic              wr_s;
   logic              rd_s;
   addr_t             addr_s;
   byte_t             wdata_s;
   logic              wr_prev_q;
   logic              rd_prev_q;
   logic              wr_fall;
   logic              rd_fall;
   logic [RCNT_W-1:0] rcnt_q;
   logic              dev_rst_q;
   logic              rst;
   mode_t             mode_q;
   logic [SCNT_W-1:0] scnt_q;
   logic              load_t1;
   byte_t             regs_q [NREGS];
   logic              sig_chg_q;
   logic              sig_chg_evt;
   addr_t             rx_a;
   sig_idx_t          tcnt_q;
   byte_t             rd_val;
   logic              irq_act;

   function automatic logic writable(input addr_t a);
      return a < OFS_RX_SIG || (a >= OFS_T1_FIRST && a <= OFS_CHAN_CTRL1);
   endfunction

   // ===========================================================
   // Pin synchronisers
   always_ff @(posedge bus.mclk)
   begin
      sync1_q <= {bus.reset_pin_n, bus.wr_n, bus.rd_n, bus.addr, bus.wdata};
      sync2_q <= sync1_q;
   end

   assign {pin_rst_n, wr_s, rd_s, addr_s, wdata_s} = sync2_q;

   always_ff @(posedge bus.mclk)
   begin
      if (rst)
      begin
         wr_prev_q <= 1'b1;
         rd_prev_q <= 1'b1;
      end
      else
      begin
         wr_prev_q <= wr_s;
         rd_prev_q <= rd_s;
      end
   end

   assign wr_fall = wr_prev_q & ~wr_s;
   assign rd_fall = rd_prev_q & ~rd_s;

   // ===========================================================
   // Reset pin qualification
   // Short glitches on the pin never reach the state
   always_ff @(posedge bus.mclk)
   begin
      if (sys_rst || pin_rst_n)
         rcnt_q <= '0;
      else if (rcnt_q != RCNT_MAX)
         rcnt_q <= rcnt_q + 1'b1;
   end

   always_ff @(posedge bus.mclk)
   begin
      if (sys_rst)
         dev_rst_q <= 1'b0;
      else if (pin_rst_n)
         dev_rst_q <= 1'b0;
      else if (rcnt_q == RCNT_MAX - 1'b1)
         dev_rst_q <= 1'b1;
   end

   assign rst = sys_rst | dev_rst_q;

   // ===========================================================
   // Line standard
   // Needs the running master clock to count out
   always_ff @(posedge bus.mclk)
   begin
      if (rst)
         mode_q <= MODE_E1;
      else
      begin
         unique case (mode_q)
            MODE_E1:
               if (wr_fall && addr_s == OFS_FRAMER_MODE1 &&
                   wdata_s[LINE_STD_BIT])
                  mode_q <= MODE_SETTLE;
            MODE_SETTLE:
               if (scnt_q == SCNT_END)
                  mode_q <= MODE_T1;
            MODE_T1:
               if (wr_fall && addr_s == OFS_FRAMER_MODE1 &&
                   !wdata_s[LINE_STD_BIT])
                  mode_q <= MODE_E1;
            default:
               mode_q <= MODE_E1;
         endcase
      end
   end

   always_ff @(posedge bus.mclk)
   begin
      if (rst || mode_q != MODE_SETTLE)
         scnt_q <= '0;
      else
         scnt_q <= scnt_q + 1'b1;
   end

   assign load_t1 = (mode_q == MODE_SETTLE) && (scnt_q == SCNT_END);

   // ===========================================================
   // Register file
   assign rx_a = OFS_RX_SIG + addr_t'(rx_sig_idx);

   always_ff @(posedge bus.mclk)
   begin
      if (rst)
      begin
         for (int i = 0; i < NREGS; i++)
            regs_q[i] <= (addr_t'(i) >= OFS_INT_MASK0 &&
                          addr_t'(i) <= OFS_INT_MASK5) ?
                         DEF_MASK : DEF_ZERO;
      end
      else
      begin
         if (load_t1)
         begin
            for (int i = 0; i < NREGS; i++)
               if (addr_t'(i) >= OFS_T1_FIRST && addr_t'(i) <= OFS_T1_LAST)
                  regs_q[i] <= t1_default(addr_t'(i));
            // Standard select stays high or the register reads back as E1
            regs_q[OFS_FRAMER_MODE1][LINE_STD_BIT] <= 1'b1;
         end
         else if (wr_fall && writable(addr_s))
            regs_q[addr_s] <= wdata_s;
         if (rx_sig_we)
            regs_q[rx_a] <= rx_sig_data;
      end
   end
   // Defaults of t1_default
   // and over the loaded range

   // ===========================================================
   // Signalling change event
   assign sig_chg_evt = rx_sig_we && (rx_sig_data != regs_q[rx_a]);

   always_ff @(posedge bus.mclk)
   begin
      if (rst)
         sig_chg_q <= 1'b0;
      else if (sig_chg_evt)
         sig_chg_q <= 1'b1;
      else if (rd_fall && addr_s == OFS_INT_STATUS)
         sig_chg_q <= 1'b0;
   end

   assign irq_act = sig_chg_q &
                    ~regs_q[OFS_INT_MASK0][SIG_CHG_MASK_BIT];

   // ===========================================================
   // Read path
   always_comb
   begin
      rd_val = DEF_ZERO;
      if (addr_s == OFS_INT_STATUS)
         rd_val[SIG_CHG_STAT_BIT] = sig_chg_q;
      else if (addr_s == OFS_DEV_STATUS)
      begin
         rd_val[STAT_T1_BIT]     = (mode_q == MODE_T1);
         rd_val[STAT_SETTLE_BIT] = (mode_q == MODE_SETTLE);
      end
      else if (addr_s <= OFS_CHAN_CTRL1)
         rd_val = regs_q[addr_s];
   end

   always_ff @(posedge bus.mclk)
   begin
      if (rst)
      begin
         bus.rdata      <= DEF_ZERO;
         bus.rdata_oe_n <= 1'b1;
      end
      else if (rd_fall)
      begin
         bus.rdata      <= rd_val;
         bus.rdata_oe_n <= 1'b0;
      end
      else if (rd_s)
         bus.rdata_oe_n <= 1'b1;
   end

   always_ff @(posedge bus.mclk)
   begin
      if (rst)
      begin
         bus.irq_n    <= 1'b1;
         bus.irq_oe_n <= 1'b1;
      end
      else
      begin
         bus.irq_n    <= ~irq_act;
         bus.irq_oe_n <= 1'b0;
      end
   end

   // ===========================================================
   // Soft reset commands
   always_ff @(posedge bus.mclk)
   begin
      if (rst)
      begin
         tx_soft_reset <= 1'b0;
         rx_soft_reset <= 1'b0;
      end
      else
      begin
         tx_soft_reset <= wr_fall && addr_s == OFS_COMMAND &&
                          wdata_s[CMD_TX_RES_BIT];
         rx_soft_reset <= wr_fall && addr_s == OFS_COMMAND &&
                          wdata_s[CMD_RX_RES_BIT];
      end
   end

   // ===========================================================
   // Transmit signalling stream
   always_ff @(posedge bus.mclk)
   begin
      if (rst)
      begin
         tcnt_q       <= '0;
         tx_sig_valid <= 1'b0;
         tx_sig_idx   <= '0;
         tx_sig_data  <= DEF_ZERO;
         line_mode_t1 <= 1'b0;
      end
      else
      begin
         tcnt_q       <= tcnt_q + 1'b1;
         tx_sig_valid <= (mode_q == MODE_E1) &&
                         regs_q[OFS_TX_SIG_CTRL][SIG_SEND_BIT] &&
                         !regs_q[OFS_CHAN_CTRL1][EXT_SLOT_BIT];
         tx_sig_idx   <= tcnt_q;
         tx_sig_data  <= regs_q[OFS_TX_SIG + addr_t'(tcnt_q)];
         line_mode_t1 <= (mode_q == MODE_T1);
      end
   end
endmodule
`default_nettype wire

// file: framer_pkg.sv
`default_nettype none
package framer_pkg;
   // ===========================================================
   // Bus widths
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int NREGS  = 128;
   localparam int SIG_W  = 4;
   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [DATA_W-1:0] byte_t;
   typedef logic [SIG_W-1:0]  sig_idx_t;

   // ===========================================================
   // Register offsets
   localparam addr_t OFS_TX_SIG          = 7'h00;
   localparam addr_t OFS_RX_SIG          = 7'h10;
   localparam addr_t OFS_T1_FIRST        = 7'h20;
   localparam addr_t OFS_FRAMER_MODE1    = 7'h21;
   localparam addr_t OFS_TX_OFFSET1      = 7'h2A;
   localparam addr_t OFS_RX_OFFSET1      = 7'h2C;
   localparam addr_t OFS_TX_PULSE_MASK0  = 7'h38;
   localparam addr_t OFS_TX_PULSE_MASK1  = 7'h39;
   localparam addr_t OFS_TX_PULSE_MASK2  = 7'h3A;
   localparam addr_t OFS_INT_MASK0       = 7'h3B;
   localparam addr_t OFS_INT_MASK5       = 7'h40;
   localparam addr_t OFS_ADDR_CMP_HIGH1  = 7'h4E;
   localparam addr_t OFS_ADDR_CMP_HIGH2  = 7'h4F;
   localparam addr_t OFS_ADDR_CMP_LOW2   = 7'h51;
   localparam addr_t OFS_T1_LAST         = 7'h61;
   localparam addr_t OFS_TX_SIG_CTRL     = 7'h62;
   localparam addr_t OFS_CHAN_CTRL1      = 7'h63;
   localparam addr_t OFS_COMMAND         = 7'h64;
   localparam addr_t OFS_INT_STATUS      = 7'h65;
   localparam addr_t OFS_DEV_STATUS      = 7'h66;

   // ===========================================================
   // Field positions
   localparam int LINE_STD_BIT     = 7;
   localparam int SIG_SEND_BIT     = 6;
   localparam int EXT_SLOT_BIT     = 4;
   localparam int SIG_CHG_MASK_BIT = 3;
   localparam int SIG_CHG_STAT_BIT = 3;
   localparam int CMD_TX_RES_BIT   = 4;
   localparam int CMD_RX_RES_BIT   = 6;
   localparam int STAT_T1_BIT      = 0;
   localparam int STAT_SETTLE_BIT  = 1;

   // ===========================================================
   // Default values
   localparam byte_t DEF_ZERO      = 8'h00;
   localparam byte_t DEF_MASK      = 8'hFF;
   localparam byte_t DEF_SLOT_OFS  = 8'h9C;
   localparam byte_t DEF_PULSE0    = 8'h40;
   localparam byte_t DEF_PULSE1    = 8'h03;
   localparam byte_t DEF_PULSE2    = 8'h7B;
   localparam byte_t DEF_ADDR_CMP1 = 8'hFD;
   localparam byte_t DEF_ADDR_CMP  = 8'hFF;

   // ===========================================================
   // Timing
   localparam int MCLK_PERIOD_NS = 100;
   localparam int RESET_MIN_NS   = 10000;
   localparam int SETTLE_MAX_NS  = 20000;
   localparam int RESET_MIN_CYC  =
      (RESET_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam int SETTLE_CYC     = SETTLE_MAX_NS / MCLK_PERIOD_NS;
   localparam int RESET_HOLD_CYC = RESET_MIN_CYC + 4;
   localparam int BUS_STROBE_CYC = 8;

   typedef enum logic [1:0]
   {
      MODE_E1     = 2'b00,
      MODE_SETTLE = 2'b01,
      MODE_T1     = 2'b11
   } mode_t;

   typedef enum logic [1:0]
   {
      HST_IDLE   = 2'b00,
      HST_ACCESS = 2'b01,
      HST_RESET  = 2'b10
   } host_state_t;

   // T1/J1 default of a control register
   function automatic byte_t t1_default(input addr_t a);
      byte_t v;
      v = DEF_ZERO;
      if (a == OFS_TX_OFFSET1 || a == OFS_RX_OFFSET1)
         v = DEF_SLOT_OFS;
      if (a == OFS_TX_PULSE_MASK0)
         v = DEF_PULSE0;
      if (a == OFS_TX_PULSE_MASK1)
         v = DEF_PULSE1;
      if (a == OFS_TX_PULSE_MASK2)
         v = DEF_PULSE2;
      if (a >= OFS_INT_MASK0 && a <= OFS_INT_MASK5)
         v = DEF_MASK;
      if (a == OFS_ADDR_CMP_HIGH1)
         v = DEF_ADDR_CMP1;
      if (a >= OFS_ADDR_CMP_HIGH2 && a <= OFS_ADDR_CMP_LOW2)
         v = DEF_ADDR_CMP;
      return v;
   endfunction
endpackage
`default_nettype wire

// file: framer_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
interface framer_bus_if
   import framer_pkg::*;
(
   input wire logic mclk
);
   logic  reset_pin_n;
   addr_t addr;
   byte_t wdata;
   logic  wr_n;
   logic  rd_n;
   byte_t rdata;
   logic  rdata_oe_n;
   logic  irq_n;
   logic  irq_oe_n;
   byte_t rdata_line;
   logic  irq_line;

   // Pull-ups hold released lines high
   assign rdata_line = rdata_oe_n ? DEF_MASK : rdata;
   assign irq_line   = irq_oe_n ? 1'b1 : irq_n;

   modport dev
   (
      input  mclk, reset_pin_n, addr, wdata, wr_n, rd_n,
      output rdata, rdata_oe_n, irq_n, irq_oe_n
   );
   modport host
   (
      input  mclk, rdata_line, irq_line,
      output reset_pin_n, addr, wdata, wr_n, rd_n
   );
endinterface
`default_nettype wire

// file: framer_host.sv
`timescale 1ns/100ps
`default_nettype none
module framer_host
   import framer_pkg::*;
(
   input  wire logic  sys_rst,
   framer_bus_if.host bus,
   input  wire logic  reset_req,
   input  wire logic  cmd_valid,
   input  wire logic  cmd_write,
   input  wire addr_t cmd_addr,
   input  wire byte_t cmd_wdata,
   output logic       cmd_ready,
   output logic       rsp_valid,
   output byte_t      rsp_rdata,
   output logic       irq
);
   localparam int CNT_W = $clog2(RESET_HOLD_CYC + 2 * BUS_STROBE_CYC);
   localparam logic [CNT_W-1:0] STROBE_END = CNT_W'(BUS_STROBE_CYC - 1);
   localparam logic [CNT_W-1:0] ACC_END    = CNT_W'(2 * BUS_STROBE_CYC - 1);
   localparam logic [CNT_W-1:0] RST_END    = CNT_W'(RESET_HOLD_CYC - 1);

   host_state_t      state_q;
   logic [CNT_W-1:0] cnt_q;
   logic             write_q;
   byte_t            rd1_q;
   byte_t            rd2_q;
   logic             irq1_q;
   logic             irq2_q;

   // ===========================================================
   // Pin synchronisers
   always_ff @(posedge bus.mclk)
   begin
      rd1_q  <= bus.rdata_line;
      rd2_q  <= rd1_q;
      irq1_q <= bus.irq_line;
      irq2_q <= irq1_q;
   end

   // ===========================================================
   // Access sequencer
   // Strobe then equal recovery lets the device resync both edges
   always_ff @(posedge bus.mclk)
   begin
      if (sys_rst)
      begin
         state_q         <= HST_IDLE;
         cnt_q           <= '0;
         write_q         <= 1'b0;
         bus.reset_pin_n <= 1'b1;
         bus.addr        <= '0;
         bus.wdata       <= DEF_ZERO;
         bus.wr_n        <= 1'b1;
         bus.rd_n        <= 1'b1;
         cmd_ready       <= 1'b0;
         rsp_valid       <= 1'b0;
         rsp_rdata       <= DEF_ZERO;
         irq             <= 1'b0;
      end
      else
      begin
         irq       <= ~irq2_q;
         rsp_valid <= 1'b0;
         cmd_ready <= 1'b0;
         unique case (state_q)
            HST_IDLE:
            begin
               cnt_q <= '0;
               if (reset_req)
               begin
                  bus.reset_pin_n <= 1'b0;
                  state_q         <= HST_RESET;
               end
               else if (cmd_valid)
               begin
                  bus.addr  <= cmd_addr;
                  bus.wdata <= cmd_wdata;
                  bus.wr_n  <= ~cmd_write;
                  bus.rd_n  <= cmd_write;
                  write_q   <= cmd_write;
                  cmd_ready <= 1'b1;
                  state_q   <= HST_ACCESS;
               end
            end
            HST_ACCESS:
            begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == STROBE_END)
               begin
                  bus.wr_n <= 1'b1;
                  bus.rd_n <= 1'b1;
                  if (!write_q)
                  begin
                     rsp_rdata <= rd2_q;
                     rsp_valid <= 1'b1;
                  end
               end
               if (cnt_q == ACC_END)
                  state_q <= HST_IDLE;
            end
            HST_RESET:
            begin
               // Clock keeps running while the pin is held
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == RST_END)
               begin
                  bus.reset_pin_n <= 1'b1;
                  cnt_q           <= '0;
                  state_q         <= HST_ACCESS;
                  write_q         <= 1'b1;
               end
            end
            default:
               state_q <= HST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: framer_bus_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module framer_bus_monitor
   import framer_pkg::*;
(
   input wire logic  mclk,
   input wire logic  sys_rst,
   input wire logic  reset_pin_n,
   input wire addr_t addr,
   input wire byte_t wdata,
   input wire logic  wr_n,
   input wire logic  rd_n,
   input wire byte_t rdata,
   input wire logic  rdata_oe_n,
   input wire logic  irq_n,
   input wire logic  irq_oe_n,
   input wire byte_t rdata_line,
   input wire logic  irq_line
);
   // ===========================================================
   // Helper counters
   logic [7:0] low_cnt_q;
   logic [7:0] gap_q;
   logic       wr_q;
   logic       rd_q;

   always_ff @(posedge mclk)
      if (sys_rst || reset_pin_n)
         low_cnt_q <= 8'h00;
      else if (low_cnt_q != 8'hFF)
         low_cnt_q <= low_cnt_q + 8'h01;

   always_ff @(posedge mclk)
   begin
      wr_q <= wr_n;
      rd_q <= rd_n;
   end

   // Saturates so long idle spells never wrap to a false short gap
   always_ff @(posedge mclk)
      if (sys_rst)
         gap_q <= 8'hFF;
      else if ((wr_q && !wr_n) || (rd_q && !rd_n))
         gap_q <= 8'h00;
      else if (gap_q != 8'hFF)
         gap_q <= gap_q + 8'h01;

   // ===========================================================
   // Properties
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   sequence s_low8(sig);
      !sig [*8] ##1 sig;
   endsequence

   chk_reset_width: assert property ($rose(reset_pin_n) |->
      low_cnt_q == 8'h68) else $error("reset pin width wrong");
   chk_rst_release: assert property (low_cnt_q >= 8'h68 |->
      rdata_oe_n && irq_oe_n) else $error("outputs driven in reset");
   chk_quiet_reset: assert property (!reset_pin_n |-> wr_n && rd_n)
      else $error("access during pin reset");
   chk_wr_strobe: assert property ($fell(wr_n) |-> s_low8(wr_n))
      else $error("write strobe length wrong");
   chk_rd_strobe: assert property ($fell(rd_n) |-> s_low8(rd_n))
      else $error("read strobe length wrong");
   chk_no_overlap: assert property (wr_n || rd_n)
      else $error("read and write together");
   chk_addr_stable: assert property ((!wr_n && !$past(wr_n)) ||
      (!rd_n && !$past(rd_n)) |-> $stable(addr) && $stable(wdata))
      else $error("address moved in strobe");
   chk_access_gap: assert property ($fell(wr_n) || $fell(rd_n) |->
      gap_q >= 8'h0F) else $error("accesses too close");
   chk_read_drive: assert property ($fell(rd_n) |-> ##[2:3] !rdata_oe_n)
      else $error("read data not driven");
   chk_read_release: assert property ($rose(rd_n) |-> ##[2:4] rdata_oe_n)
      else $error("read data not released");
   chk_idle_release: assert property (rd_n [*5] |-> rdata_oe_n)
      else $error("data driven while idle");
   chk_data_steady: assert property (!rdata_oe_n && !$past(rdata_oe_n) |->
      $stable(rdata) && rdata_line == rdata)
      else $error("read data moved while driven");
   chk_irq_idle: assert property (irq_oe_n |-> irq_n && irq_line)
      else $error("interrupt active while released");
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
   import framer_pkg::*;
();
   logic     mclk;
   logic     sys_rst;
   logic     reset_req;
   logic     cmd_valid;
   logic     cmd_write;
   addr_t    cmd_addr;
   byte_t    cmd_wdata;
   logic     cmd_ready;
   logic     rsp_valid;
   byte_t    rsp_rdata;
   logic     irq;
   logic     rx_sig_we;
   sig_idx_t rx_sig_idx;
   byte_t    rx_sig_data;
   logic     tx_sig_valid;
   sig_idx_t tx_sig_idx;
   byte_t    tx_sig_data;
   logic     line_mode_t1;
   logic     tx_soft_reset;
   logic     rx_soft_reset;
   int       mismatches;
   int       checked;
   int       cycles;
   int       tx_pulses;
   int       rx_pulses;
   byte_t    rd_v;
   byte_t    tx_img [16];

   // ===========================================================
   // Structure
   framer_bus_if link (.mclk(mclk));
   framer_dev framer_dev_i (.sys_rst(sys_rst), .bus(link),
      .rx_sig_we(rx_sig_we), .rx_sig_idx(rx_sig_idx),
      .rx_sig_data(rx_sig_data), .tx_sig_valid(tx_sig_valid),
      .tx_sig_idx(tx_sig_idx), .tx_sig_data(tx_sig_data),
      .line_mode_t1(line_mode_t1), .tx_soft_reset(tx_soft_reset),
      .rx_soft_reset(rx_soft_reset));
   framer_host framer_host_i (.sys_rst(sys_rst), .bus(link),
      .reset_req(reset_req), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .irq(irq));
   framer_bus_monitor framer_bus_monitor_i (.mclk(mclk),
      .sys_rst(sys_rst), .reset_pin_n(link.reset_pin_n),
      .addr(link.addr), .wdata(link.wdata), .wr_n(link.wr_n),
      .rd_n(link.rd_n), .rdata(link.rdata), .rdata_oe_n(link.rdata_oe_n),
      .irq_n(link.irq_n), .irq_oe_n(link.irq_oe_n),
      .rdata_line(link.rdata_line), .irq_line(link.irq_line));

   // ===========================================================
   // Common tasks
   task automatic tick(input int n = 1);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Request held until the edge that samples cmd_ready high
   task automatic access(input logic wr, input addr_t a, input byte_t d);
      int n;
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_addr = a;
      cmd_wdata = d;
      for (n = 0; n < 40 && cmd_ready !== 1'b1; n++)
         tick();
      check("cmd_ready", cmd_ready, 8'h01);
      tick();
      cmd_valid = 1'b0;
      tick();
      if (!wr)
      begin
         for (n = 0; n < 40 && rsp_valid !== 1'b1; n++)
            tick();
         rd_v = rsp_rdata;
      end
   endtask

   task automatic rx_write(input sig_idx_t i, input byte_t d);
      rx_sig_we = 1'b1;
      rx_sig_idx = i;
      rx_sig_data = d;
      tick();
      rx_sig_we = 1'b0;
      tick(6);
   endtask

   function automatic byte_t exp_t1(input addr_t a);
      case (a)
         7'h21: return 8'h80;
         7'h2A, 7'h2C: return 8'h9C;
         7'h38: return 8'h40;
         7'h39: return 8'h03;
         7'h3A: return 8'h7B;
         7'h4E: return 8'hFD;
         7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3F, 7'h40: return 8'hFF;
         7'h4F, 7'h50, 7'h51: return 8'hFF;
         default: return 8'h00;
      endcase
   endfunction

   // ===========================================================
   // Scenarios
   task automatic t_defaults;
      check("t1_after_reset", line_mode_t1, 8'h00);
      access(1'b0, OFS_FRAMER_MODE1, 8'h00);
      check("fmode1_e1", rd_v, 8'h00);
      access(1'b0, OFS_DEV_STATUS, 8'h00);
      check("status_e1", rd_v, 8'h00);
   endtask

   task automatic t_send_sig;
      for (int i = 0; i < 16; i++)
      begin
         tx_img[i] = 8'h30 + 8'(i);
         access(1'b1, addr_t'(i), tx_img[i]);
      end
      access(1'b1, OFS_TX_SIG_CTRL, 8'h40);
      tick(4);
      for (int i = 0; i < 16; i++)
      begin
         check("tx_sig_valid", tx_sig_valid, 8'h01);
         check("tx_sig_data", tx_sig_data, tx_img[tx_sig_idx]);
         tick();
      end
      access(1'b1, OFS_CHAN_CTRL1, 8'h10);
      tick(4);
      check("ext_slot_stop", tx_sig_valid, 8'h00);
      access(1'b1, OFS_CHAN_CTRL1, 8'h00);
   endtask

   task automatic t_sig_change;
      access(1'b1, OFS_INT_MASK0, 8'hF7);
      rx_write(4'h3, 8'h5A);
      check("irq_on_change", irq, 8'h01);
      access(1'b1, OFS_RX_SIG + 7'h03, 8'h00);
      access(1'b0, OFS_RX_SIG + 7'h03, 8'h00);
      check("rx_sig_read_only", rd_v, 8'h5A);
      access(1'b0, OFS_INT_STATUS, 8'h00);
      check("change_status", rd_v[SIG_CHG_STAT_BIT], 8'h01);
      tick(6);
      check("irq_cleared", irq, 8'h00);
      rx_write(4'h3, 8'h5A);
      check("irq_same_data", irq, 8'h00);
      access(1'b1, OFS_INT_MASK0, 8'hFF);
      // Let the mask land before the change arrives
      tick(4);
      rx_write(4'h3, 8'hA5);
      check("irq_masked", irq, 8'h00);
      access(1'b0, OFS_INT_STATUS, 8'h00);
   endtask

   task automatic t_soft_reset;
      access(1'b1, OFS_COMMAND, 8'h50);
      tick(8);
      access(1'b1, OFS_COMMAND, 8'h10);
      tick(8);
      check("tx_soft_pulses", 8'(tx_pulses), 8'h02);
      check("rx_soft_pulses", 8'(rx_pulses), 8'h01);
      access(1'b0, OFS_COMMAND, 8'h00);
      check("command_write_only", rd_v, 8'h00);
   endtask

   task automatic t_line_standard;
      int t0;
      access(1'b1, 7'h2D, 8'h55);
      access(1'b1, OFS_FRAMER_MODE1, 8'h80);
      t0 = cycles;
      access(1'b0, OFS_DEV_STATUS, 8'h00);
      check("settling", rd_v[STAT_SETTLE_BIT], 8'h01);
      access(1'b1, OFS_TX_PULSE_MASK0, 8'h11);
      while (line_mode_t1 !== 1'b1 && cycles - t0 < 300)
         tick();
      check("settle_in_time", 8'(cycles - t0 <= 206), 8'h01);
      for (int a = OFS_T1_FIRST; a <= OFS_T1_LAST; a++)
      begin
         access(1'b0, addr_t'(a), 8'h00);
         if (a < 7'h29)
            check("t1_mode", rd_v, exp_t1(addr_t'(a)));
         else if (a < 7'h3B)
            check("t1_line", rd_v, exp_t1(addr_t'(a)));
         else if (a < 7'h4E)
            check("t1_mask", rd_v, exp_t1(addr_t'(a)));
         else
            check("t1_slot", rd_v, exp_t1(addr_t'(a)));
      end
      access(1'b0, OFS_DEV_STATUS, 8'h00);
      check("status_t1", rd_v, 8'h01);
      check("no_send_in_t1", tx_sig_valid, 8'h00);
   endtask

   task automatic t_pin_reset;
      int n;
      check("t1_before_reset", line_mode_t1, 8'h01);
      access(1'b1, 7'h2D, 8'hAA);
      tick(20);
      reset_req = 1'b1;
      for (n = 0; n < 40 && link.reset_pin_n !== 1'b0; n++)
         tick();
      reset_req = 1'b0;
      tick(106);
      check("t1_cleared", line_mode_t1, 8'h00);
      access(1'b0, 7'h2D, 8'h00);
      check("idle_code_cleared", rd_v, 8'h00);
      access(1'b0, OFS_INT_MASK0, 8'h00);
      check("mask_default", rd_v, 8'hFF);
      access(1'b0, OFS_FRAMER_MODE1, 8'h00);
      check("back_to_e1", rd_v, 8'h00);
   endtask

   // Software return from T1 to E1, without a pin reset
   task automatic t_back_to_e1;
      access(1'b1, OFS_FRAMER_MODE1, 8'h80);
      for (int n = 0; n < 300 && line_mode_t1 !== 1'b1; n++)
         tick();
      check("t1_again", line_mode_t1, 8'h01);
      access(1'b1, OFS_FRAMER_MODE1, 8'h00);
      tick(6);
      check("e1_again", line_mode_t1, 8'h00);
      access(1'b0, OFS_DEV_STATUS, 8'h00);
      check("status_e1_again", rd_v, 8'h00);
   endtask

   // ===========================================================
   // Clock, watchdog and main sequence
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // Ceiling well above the few thousand cycles the run needs
   always @(posedge mclk)
   begin
      cycles++;
      if (tx_soft_reset === 1'b1)
         tx_pulses++;
      if (rx_soft_reset === 1'b1)
         rx_pulses++;
      if (cycles == 20000)
      begin
         mismatches++;
         results();
      end
   end

   initial
   begin
      sys_rst = 1'b1;
      reset_req = 1'b0;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_addr = 7'h00;
      cmd_wdata = 8'h00;
      rx_sig_we = 1'b0;
      rx_sig_idx = 4'h0;
      rx_sig_data = 8'h00;
      tick(4);
      sys_rst = 1'b0;
      t_defaults();
      t_send_sig();
      t_sig_change();
      t_soft_reset();
      t_line_standard();
      t_pin_reset();
      t_back_to_e1();
      results();
   end
endmodule
`default_nettype wire
